//--- inoj_exec.sv
// Execution unit for increment, increment-skip, OR and jump instructions
`include "inoj_defines.svh"

module inoj_exec
  import inoj_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire inoj_pkg::inoj_instr_t instr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] program_counter_high_latch,
  output logic instr_ready,
  output logic [7:0] acc,
  output logic zero_flag,
  output inoj_pkg::inoj_fwr_t file_wr,
  output logic [12:0] pc,
  output logic pc_load,
  output logic nop_cycle
);

  inoj_state_t state;
  inoj_state_t next_state;
  logic [7:0] alu_result;
  logic alu_zero;

  inoj_alu u_alu (
    .op(instr.op),
    .acc(acc),
    .fdata(file_rdata),
    .lit(instr.lit),
    .result(alu_result),
    .zero(alu_zero)
  );

  // Instruction decode; only acted on when taken
  wire logic take = instr_valid && instr_ready;
  wire logic is_inc = (instr.op == op_increment_file_reg);
  wire logic is_incsz = (instr.op == op_increment_skip_on_zero);
  wire logic is_orl = (instr.op == op_or_literal_into_accumulator);
  wire logic is_orf = (instr.op == op_or_accumulator_with_file_reg);
  wire logic is_jump = (instr.op == op_unconditional_jump);
  wire logic file_op = is_inc || is_incsz || is_orf;

  // Destination routing; OR-literal always lands in the accumulator
  wire logic wr_acc = take && (is_orl || (file_op && instr.dest == `INOJ_DEST_ACC));
  wire logic wr_file = take && file_op && (instr.dest == `INOJ_DEST_FILE);
  // Skip-increment and jump leave the flag alone
  wire logic wr_zero = take && (is_inc || is_orl || is_orf);
  wire logic do_skip = take && is_incsz && alu_zero;
  wire logic do_jump = take && is_jump;
  wire logic [12:0] jump_pc = {program_counter_high_latch[`INOJ_PCH_HI:`INOJ_PCH_LO], instr.target};

  // Second cycle of jump or skip is a forced no-op
  always_comb begin
    case (state)
      st_run: next_state = (do_skip || do_jump) ? st_nop : st_run;
      st_nop: next_state = st_run;
      default: next_state = st_run;
    endcase
  end

  // Next values of the architectural outputs
  wire logic [7:0] next_acc = wr_acc ? alu_result : acc;
  wire logic next_zero_flag = wr_zero ? alu_zero : zero_flag;
  wire inoj_fwr_t next_file_wr = '{en: wr_file, addr: instr.faddr, data: alu_result};
  wire logic [12:0] next_pc = do_jump ? jump_pc : pc;

  // State and handshake; ready drops for exactly the no-op cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= st_run;
      instr_ready <= 1'b1;
      nop_cycle <= 1'b0;
    end else begin
      state <= next_state;
      instr_ready <= (next_state == st_run);
      nop_cycle <= (next_state == st_nop);
    end
  end

  // Data outputs; file write and pc load are one-cycle pulses
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc <= `INOJ_ACC_RST;
      zero_flag <= 1'b0;
      file_wr <= `INOJ_FWR_RST;
      pc <= `INOJ_PC_RST;
      pc_load <= 1'b0;
    end else begin
      acc <= next_acc;
      zero_flag <= next_zero_flag;
      file_wr <= next_file_wr;
      pc <= next_pc;
      pc_load <= do_jump;
    end
  end

  // Checks: a small counter tracks cycles since the last taken two-cycle op
  logic [1:0] long_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      long_cnt <= 2'h0;
    end else begin
      long_cnt <= (do_skip || do_jump) ? 2'h1 : (long_cnt == 2'h0 ? 2'h0 : long_cnt + 2'h1);
    end
  end

  // Skip-increment to the accumulator: no file write, flag left alone
  property p_incsz_route;
    @(posedge mclk) disable iff (rst)
      (take && is_incsz && instr.dest == `INOJ_DEST_ACC) |=>
        acc == 8'($past(file_rdata) + `INOJ_INC_STEP) && !file_wr.en && $stable(zero_flag);
  endproperty
  a_incsz_route: assert property (p_incsz_route) else $error("skip-increment to accumulator wrong");

  property p_incsz_dest;
    @(posedge mclk) disable iff (rst)
      (take && is_incsz && instr.dest == `INOJ_DEST_FILE) |=>
        file_wr.en && file_wr.data == 8'($past(file_rdata) + `INOJ_INC_STEP) && $stable(zero_flag);
  endproperty
  a_incsz_dest: assert property (p_incsz_dest) else $error("skip-increment file write or flag wrong");

  property p_skip_nop;
    @(posedge mclk) disable iff (rst)
      do_skip |=> nop_cycle && !instr_ready ##1 !nop_cycle && instr_ready;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("zero skip did not insert one no-op cycle");

  property p_noskip;
    @(posedge mclk) disable iff (rst)
      (take && is_incsz && !alu_zero) |=> instr_ready && !nop_cycle;
  endproperty
  a_noskip: assert property (p_noskip) else $error("nonzero skip-increment stalled");

  property p_jump_low;
    @(posedge mclk) disable iff (rst)
      do_jump |=> pc_load && pc[10:0] == $past(instr.target);
  endproperty
  a_jump_low: assert property (p_jump_low) else $error("jump target not in low pc bits");

  property p_jump_high;
    @(posedge mclk) disable iff (rst)
      do_jump |=> pc[12:11] == $past(program_counter_high_latch[4:3]);
  endproperty
  a_jump_high: assert property (p_jump_high) else $error("pc high bits not from latch");

  property p_jump_two;
    @(posedge mclk) disable iff (rst)
      do_jump |=> $stable(zero_flag) && $stable(acc) && !instr_ready ##1 instr_ready && long_cnt == 2'h2;
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump not two cycles or touched flags");

  property p_orl;
    @(posedge mclk) disable iff (rst)
      (take && is_orl) |=> acc == ($past(acc) | $past(instr.lit)) && zero_flag == (acc == `INOJ_ZERO8);
  endproperty
  a_orl: assert property (p_orl) else $error("or-literal result or zero flag wrong");

  property p_inc_acc;
    @(posedge mclk) disable iff (rst)
      (take && is_inc && instr.dest == `INOJ_DEST_ACC) |=>
        acc == 8'($past(file_rdata) + `INOJ_INC_STEP) && !file_wr.en;
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("increment to accumulator wrong");

  property p_orf_file;
    @(posedge mclk) disable iff (rst)
      (take && is_orf && instr.dest == `INOJ_DEST_FILE) |=>
        file_wr.en && file_wr.data == ($past(acc) | $past(file_rdata)) && $stable(acc);
  endproperty
  a_orf_file: assert property (p_orf_file) else $error("or-with-file write wrong");

  property p_zero;
    @(posedge mclk) disable iff (rst)
      wr_zero |=> zero_flag == ($past(alu_result) == `INOJ_ZERO8);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag does not match result");

  property p_wrap;
    @(posedge mclk) disable iff (rst)
      (take && is_inc && file_rdata == 8'hFF && instr.dest == `INOJ_DEST_FILE) |=>
        file_wr.data == `INOJ_ZERO8 && zero_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("increment of 0xFF did not wrap to zero");

  // Offers during the no-op cycle are dropped, so nothing may move
  property p_refused;
    @(posedge mclk) disable iff (rst)
      (instr_valid && !instr_ready) |=> $stable(acc) && $stable(zero_flag) && !file_wr.en && !pc_load;
  endproperty
  a_refused: assert property (p_refused) else $error("instruction acted on during no-op cycle");

  // Ready only drops for the substituted no-op cycle
  property p_ready_low_nop;
    @(posedge mclk) disable iff (rst)
      !instr_ready |-> nop_cycle;
  endproperty
  a_ready_low_nop: assert property (p_ready_low_nop) else $error("ready low outside no-op cycle");

  property p_orf_acc;
    @(posedge mclk) disable iff (rst)
      (take && is_orf && instr.dest == `INOJ_DEST_ACC) |=>
        acc == ($past(acc) | $past(file_rdata)) && !file_wr.en;
  endproperty
  a_orf_acc: assert property (p_orf_acc) else $error("or-with-file to accumulator wrong");

  // Write-back must carry the addressed register, not a stale one
  property p_inc_file;
    @(posedge mclk) disable iff (rst)
      (take && is_inc && instr.dest == `INOJ_DEST_FILE) |=>
        file_wr.en && file_wr.addr == $past(instr.faddr) && $stable(acc) &&
        file_wr.data == 8'($past(file_rdata) + `INOJ_INC_STEP);
  endproperty
  a_inc_file: assert property (p_inc_file) else $error("increment write-back wrong");

  // Only a jump may move the program counter
  property p_pc_hold;
    @(posedge mclk) disable iff (rst)
      !do_jump |=> $stable(pc) && !pc_load;
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("program counter moved without a jump");

  c_skip: cover property (@(posedge mclk) disable iff (rst) do_skip);
  c_jump: cover property (@(posedge mclk) disable iff (rst) do_jump ##2 take);
  c_orf_acc: cover property (@(posedge mclk) disable iff (rst) take && is_orf && instr.dest == `INOJ_DEST_ACC);
  c_wrap: cover property (@(posedge mclk) disable iff (rst) take && is_inc && file_rdata == 8'hFF);

endmodule

//--- inoj_defines.svh
// Constants for the increment/OR/jump execution block
`ifndef INOJ_DEFINES_SVH
`define INOJ_DEFINES_SVH

`define INOJ_ACC_RST 8'h00
`define INOJ_PC_RST 13'h0000
`define INOJ_FWR_RST 16'h0000
`define INOJ_DEST_ACC 1'b0
`define INOJ_DEST_FILE 1'b1
`define INOJ_INC_STEP 8'h01
`define INOJ_ZERO8 8'h00
`define INOJ_PCH_HI 4
`define INOJ_PCH_LO 3
`define INOJ_LONG_CYCLES 2

`endif

//--- inoj_pkg.sv
// Types and helper functions for the increment/OR/jump execution block
package inoj_pkg;

  typedef enum logic [4:0] {
    op_increment_file_reg = 5'h01,
    op_increment_skip_on_zero = 5'h02,
    op_or_literal_into_accumulator = 5'h04,
    op_or_accumulator_with_file_reg = 5'h08,
    op_unconditional_jump = 5'h10
  } inoj_op_t;

  typedef enum logic [1:0] {
    st_run = 2'h1,
    st_nop = 2'h2
  } inoj_state_t;

  typedef struct packed {
    inoj_op_t op;
    logic [6:0] faddr;
    logic dest;
    logic [7:0] lit;
    logic [10:0] target;
  } inoj_instr_t;

  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } inoj_fwr_t;

  // Eight-bit increment, carry dropped on purpose
  function automatic logic [7:0] inoj_inc8(input logic [7:0] v);
    inoj_inc8 = v + 8'h01;
  endfunction

  function automatic logic inoj_zero8(input logic [7:0] v);
    inoj_zero8 = (v == 8'h00);
  endfunction

endpackage

//--- inoj_alu.sv
// Combinational result path for increment and OR operations
module inoj_alu
  import inoj_pkg::*;
(
  input wire inoj_pkg::inoj_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] fdata,
  input wire logic [7:0] lit,
  output logic [7:0] result,
  output logic zero
);

  // Both increments share one adder; wraps at 256
  wire logic [7:0] inc_val = inoj_inc8(fdata);
  wire logic is_inc = (op == op_increment_file_reg) || (op == op_increment_skip_on_zero);
  wire logic is_orl = (op == op_or_literal_into_accumulator);
  wire logic is_orf = (op == op_or_accumulator_with_file_reg);

  // Result select; jump has no data result
  assign result = is_inc ? inc_val :
                  is_orl ? (acc | lit) :
                  is_orf ? (acc | fdata) :
                  8'h00;
  assign zero = inoj_zero8(result);

endmodule

//--- test_inc_or_jump_execute.sv
// Self-checking bench for the increment/OR/jump execution block
module test_inc_or_jump_execute;
  timeunit 1ns;
  timeprecision 1ps;
  import inoj_pkg::*;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  inoj_instr_t instr = '0;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] program_counter_high_latch = 8'h00;
  logic instr_ready, zero_flag, pc_load, nop_cycle;
  logic [7:0] acc;
  inoj_fwr_t file_wr;
  logic [12:0] pc;
  int mismatches = 0;
  int n_compared = 0;

  // 50 MHz clock
  always #10 mclk = ~mclk;

  inoj_exec u_dut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
    .program_counter_high_latch(program_counter_high_latch), .instr_ready(instr_ready), .acc(acc),
    .zero_flag(zero_flag), .file_wr(file_wr), .pc(pc), .pc_load(pc_load), .nop_cycle(nop_cycle));

  // Single exit point for the whole run
  task automatic end_sim;
    $display("Counts: %0d compared, %0d mismatches", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Four-state compare so an unknown never matches
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // One instruction, taken at the second edge; keep offers a literal OR in the cycle after
  task automatic issue(input inoj_op_t op, input logic dest, input logic [7:0] lit, input logic [7:0] fd,
                       input logic [10:0] tgt, input bit keep);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr <= '{op: op, faddr: 7'h2A, dest: dest, lit: lit, target: tgt};
    file_rdata <= fd;
    @(posedge mclk);
    if (keep) begin
      instr <= '{op: op_or_literal_into_accumulator, faddr: 7'h2A, dest: 1'b0, lit: 8'hFF, target: 11'h000};
    end else begin
      instr_valid <= 1'b0;
    end
    #1;
  endtask

  task automatic t_reset;
    chk("ready", 16'h0001, {15'h0, instr_ready});
    chk("acc", 16'h0000, {8'h0, acc});
    chk("zero", 16'h0000, {15'h0, zero_flag});
    chk("file_wr", 16'h0000, file_wr);
    chk("pc", 16'h0000, {3'h0, pc});
    chk("pulses", 16'h0000, {14'h0, pc_load, nop_cycle});
    $display("test reset done");
  endtask

  task automatic t_orlit;
    issue(op_or_literal_into_accumulator, 1'b0, 8'h00, 8'h77, 11'h000, 1'b0);
    chk("acc", 16'h0000, {8'h0, acc});
    chk("zero", 16'h0001, {15'h0, zero_flag});
    chk("wr_en", 16'h0000, {15'h0, file_wr.en});
    issue(op_or_literal_into_accumulator, 1'b0, 8'h5A, 8'h77, 11'h000, 1'b0);
    chk("acc", 16'h005A, {8'h0, acc});
    chk("zero", 16'h0000, {15'h0, zero_flag});
    $display("test or-literal done");
  endtask

  task automatic t_inc;
    issue(op_increment_file_reg, 1'b1, 8'h00, 8'hFF, 11'h000, 1'b0);
    chk("file_wr", {1'b1, 7'h2A, 8'h00}, file_wr);
    chk("zero", 16'h0001, {15'h0, zero_flag});
    chk("acc", 16'h005A, {8'h0, acc});
    issue(op_increment_file_reg, 1'b0, 8'h00, 8'h3C, 11'h000, 1'b0);
    chk("acc", 16'h003D, {8'h0, acc});
    chk("zero", 16'h0000, {15'h0, zero_flag});
    chk("wr_en", 16'h0000, {15'h0, file_wr.en});
    $display("test increment done");
  endtask

  task automatic t_orfile;
    issue(op_or_accumulator_with_file_reg, 1'b1, 8'h00, 8'hC0, 11'h000, 1'b0);
    chk("file_wr", {1'b1, 7'h2A, 8'hFD}, file_wr);
    chk("acc", 16'h003D, {8'h0, acc});
    issue(op_or_accumulator_with_file_reg, 1'b0, 8'h00, 8'h42, 11'h000, 1'b0);
    chk("acc", 16'h007F, {8'h0, acc});
    chk("zero", 16'h0000, {15'h0, zero_flag});
    $display("test or-file done");
  endtask

  task automatic t_skip;
    issue(op_increment_skip_on_zero, 1'b0, 8'h00, 8'h41, 11'h000, 1'b0);
    chk("acc", 16'h0042, {8'h0, acc});
    chk("ready_nop", 16'h0002, {14'h0, instr_ready, nop_cycle});
    issue(op_increment_skip_on_zero, 1'b1, 8'h00, 8'hFF, 11'h000, 1'b0);
    chk("file_wr", {1'b1, 7'h2A, 8'h00}, file_wr);
    chk("zero", 16'h0000, {15'h0, zero_flag});
    chk("ready_nop", 16'h0001, {14'h0, instr_ready, nop_cycle});
    @(posedge mclk);
    #1;
    chk("ready_nop", 16'h0002, {14'h0, instr_ready, nop_cycle});
    issue(op_increment_skip_on_zero, 1'b0, 8'h00, 8'hFF, 11'h000, 1'b0);
    chk("acc", 16'h0000, {8'h0, acc});
    chk("ready_nop", 16'h0001, {14'h0, instr_ready, nop_cycle});
    $display("test skip done");
  endtask

  // Flag is cleared first: a jump that wrongly wrote it would set it
  task automatic t_jump;
    issue(op_increment_file_reg, 1'b1, 8'h00, 8'h10, 11'h000, 1'b0);
    chk("file_wr", {1'b1, 7'h2A, 8'h11}, file_wr);
    chk("zero", 16'h0000, {15'h0, zero_flag});
    @(posedge mclk);
    program_counter_high_latch <= 8'h0F;
    issue(op_unconditional_jump, 1'b0, 8'h00, 8'h00, 11'h7FF, 1'b1);
    chk("pc", 16'h0FFF, {3'h0, pc});
    chk("load_ready_nop", 16'h0005, {13'h0, pc_load, instr_ready, nop_cycle});
    chk("zero", 16'h0000, {15'h0, zero_flag});
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    chk("acc", 16'h0000, {8'h0, acc});
    chk("load_ready_nop", 16'h0002, {13'h0, pc_load, instr_ready, nop_cycle});
    @(posedge mclk);
    program_counter_high_latch <= 8'hF0;
    issue(op_unconditional_jump, 1'b0, 8'h00, 8'h00, 11'h000, 1'b0);
    chk("pc", 16'h1000, {3'h0, pc});
    $display("test jump done");
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    t_reset();
    rst <= 1'b0;
    t_orlit();
    t_inc();
    t_orfile();
    t_skip();
    t_jump();
    end_sim();
  end

  // Watchdog, generous against about 34 cycles of tests
  initial begin
    #8000;
    mismatches++;
    $display("unexpected watchdog: expected finish, seen timeout");
    end_sim();
  end
endmodule
